// *** pkg/acfg_defs.svh ***
`ifndef ACFG_DEFS_SVH
`define ACFG_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define ACFG_OFF_STATUS 8'h00
`define ACFG_OFF_GLOBAL 8'h01
`define ACFG_OFF_FORMAT 8'h02
`define ACFG_OFF_AVG 8'h03

// ****************************************
// reset values
// ****************************************
`define ACFG_RST_GLOBAL 8'h00
`define ACFG_RST_FORMAT 8'h00
`define ACFG_RST_AVG 8'h00
`define ACFG_RST_BROWNOUT 1'b1

// ****************************************
// field positions
// ****************************************
`define ACFG_GL_CRC 6
`define ACFG_GL_MINMAX 5
`define ACFG_GL_WINDOW 4
`define ACFG_GL_FORCE 2
`define ACFG_GL_TRIM 1
`define ACFG_GL_SOFTRST 0
`define ACFG_ST_ALWAYS1 7
`define ACFG_ST_BROWNOUT 0
`define ACFG_FM_PATTERN 7
`define ACFG_FM_TAG_HI 5
`define ACFG_FM_TAG_LO 4
`define ACFG_FM_MODE_HI 1
`define ACFG_FM_MODE_LO 0
`define ACFG_AV_RATIO_HI 2

// ****************************************
// writable masks, reserved bits stay zero
// ****************************************
`define ACFG_MASK_GLOBAL 8'h76
`define ACFG_MASK_FORMAT 8'hb3
`define ACFG_MASK_AVG 8'h07

// ****************************************
// data path and link constants
// ****************************************
`define ACFG_TEST_CODE 12'ha5a
`define ACFG_FRAME_BITS 5'h18
`define ACFG_DATA_START 5'h10
`define ACFG_OP_READ 8'h10
`define ACFG_OP_WRITE 8'h08

`endif

// *** pkg/acfg_pkg.sv ***
package acfg_pkg;

    typedef enum logic [1:0] {
        ACFG_TAG_NONE = 2'h0,
        ACFG_TAG_CHANNEL = 2'h1,
        ACFG_TAG_STATUS = 2'h2,
        ACFG_TAG_RESERVED = 2'h3
    } acfg_tag_t;

    typedef logic [1:0] acfg_spi_mode_t;
    typedef logic [2:0] acfg_ratio_t;

endpackage

// *** hw/acfg_sync.sv ***
`timescale 1ns/100ps

module acfg_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_width_check
        $error("acfg_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // acfg_sync

// *** hw/acfg_reg_bank.sv ***
`timescale 1ns/100ps
`include "acfg_defs.svh"

// Behaviour
// - the checksum enable bit turns the link checksum on for output and input, else it is off; the link here has no checksum, the bit only drives crc_enable.
// - setting the minmax tracking bit clears the statistics and then lets them update.
// - while minmax tracking is off the statistics registers do not update.
// - the window compare bit enables the comparator, and when clear holds it in reset.
// - while force analog is set every channel is an analog input.
// - writing one to offset trim starts calibration and the bit clears itself when it ends.
// - writing one to the soft reset bit returns every register to its default.
// - after a soft reset the soft reset bit reads zero and the brownout flag is set.
// - while the test pattern bit is set every data word is the fixed code a5a.
// - tag select one appends the four bit channel number to each data word.
// - tag select two appends four status flag bits to each data word.
// - tag select zero appends nothing and three is reserved.
// - the two mode bits give clock polarity and phase and the host clocks to match.
// - averaging ratio zero averages nothing and code n averages two to the n samples.
// - the brownout flag is set at power up or soft reset and cleared by writing one.
module acfg_reg_bank
    import acfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic trim_done,
    input wire logic conv_valid,
    input wire logic [11:0] conv_data,
    input wire logic [3:0] conv_channel,
    input wire logic [3:0] conv_status,
    output logic crc_enable,
    output logic minmax_clear,
    output logic minmax_update,
    output logic window_compare_enable,
    output logic window_compare_reset,
    output logic force_analog_all,
    output logic trim_start,
    output acfg_pkg::acfg_spi_mode_t spi_mode,
    output acfg_pkg::acfg_ratio_t averaging_ratio,
    output logic [7:0] average_samples,
    output logic out_valid,
    output logic [15:0] out_word,
    output logic out_tag_valid
);
    import acfg_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pins_sync;
    logic cs_n_s;
    logic sclk_s;
    logic mosi_s;

    acfg_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({~spi_cs_n, spi_sclk, spi_mosi}),
        .sync_out(pins_sync)
    );

    // select travels inverted so cleared stages mean deselected, no false frame after reset
    assign cs_n_s = ~pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign mosi_s = pins_sync[0];

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] global_reg;
    logic [7:0] format_reg;
    logic [7:0] avg_reg;
    logic brownout_reg;
    logic soft_rst_reg;
    logic sclk_d_reg;
    logic [4:0] bit_cnt_reg;
    logic [23:0] shift_reg;
    logic [7:0] rd_byte_reg;
    acfg_spi_mode_t frame_mode_reg;

    // ****************************************
    // link edge decode
    // ****************************************
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    // mode is held for a whole frame so a write to it cannot split a frame
    wire sample_on_rise = frame_mode_reg[1] == frame_mode_reg[0];
    wire sample_edge = ~cs_n_s & (sample_on_rise ? sclk_rise : sclk_fall);
    wire shift_edge = ~cs_n_s & (sample_on_rise ? sclk_fall : sclk_rise);
    wire [23:0] shift_next = {shift_reg[22:0], mosi_s};
    wire frame_done = sample_edge && (bit_cnt_reg == `ACFG_FRAME_BITS - 5'h1);
    wire wr_go = frame_done && (shift_reg[22:15] == `ACFG_OP_WRITE);
    wire [7:0] wr_addr = shift_reg[14:7];
    wire [7:0] wr_data = shift_next[7:0];
    wire addr_ready = sample_edge && (bit_cnt_reg == `ACFG_DATA_START - 5'h1);
    wire [7:0] rd_addr = shift_next[7:0];
    wire rd_op = shift_next[15:8] == `ACFG_OP_READ;
    wire [4:0] out_idx = bit_cnt_reg - `ACFG_DATA_START;

    function automatic logic hit(input logic go, input logic [7:0] a, input logic [7:0] off);
        hit = go && (a == off);
    endfunction

    wire wr_status = hit(wr_go, wr_addr, `ACFG_OFF_STATUS);
    wire wr_global = hit(wr_go, wr_addr, `ACFG_OFF_GLOBAL);
    wire wr_format = hit(wr_go, wr_addr, `ACFG_OFF_FORMAT);
    wire wr_avg = hit(wr_go, wr_addr, `ACFG_OFF_AVG);

    // ****************************************
    // read decode
    // ****************************************
    // reserved read zero
    wire [7:0] status_view = {1'b1, 6'h00, brownout_reg};
    wire [7:0] rd_value =
        (rd_addr == `ACFG_OFF_STATUS) ? status_view :
        (rd_addr == `ACFG_OFF_GLOBAL) ? global_reg :
        (rd_addr == `ACFG_OFF_FORMAT) ? format_reg :
        (rd_addr == `ACFG_OFF_AVG) ? avg_reg : 8'h00;

    // ****************************************
    // configuration next values
    // ****************************************
    logic [7:0] global_next;
    logic trim_set;
    logic minmax_rise;

    assign trim_set = wr_global & wr_data[`ACFG_GL_TRIM];
    always_comb begin
        global_next = global_reg;
        if (wr_global) begin
            global_next = (wr_data & `ACFG_MASK_GLOBAL) | (global_reg & 8'h02);
        end
        // trim self clear, a new start wins
        if (trim_done && !trim_set) begin
            global_next[`ACFG_GL_TRIM] = 1'b0;
        end
    end
    assign minmax_rise = global_next[`ACFG_GL_MINMAX] & ~global_reg[`ACFG_GL_MINMAX];

    // ****************************************
    // register file
    // ****************************************
    // soft reset to defaults
    always_ff @(posedge clk) begin
        if (!rst_n || soft_rst_reg) begin
            global_reg <= `ACFG_RST_GLOBAL;
            format_reg <= `ACFG_RST_FORMAT;
            avg_reg <= `ACFG_RST_AVG;
        end else begin
            global_reg <= global_next;
            if (wr_format) begin
                format_reg <= wr_data & `ACFG_MASK_FORMAT;
            end
            if (wr_avg) begin
                avg_reg <= wr_data & `ACFG_MASK_AVG;
            end
        end
    end

    // soft reset takes effect one cycle after the write frame ends
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_global & wr_data[`ACFG_GL_SOFTRST];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            brownout_reg <= `ACFG_RST_BROWNOUT;
        end else if (soft_rst_reg) begin
            brownout_reg <= 1'b1;
        end else if (wr_status && wr_data[`ACFG_ST_BROWNOUT]) begin
            brownout_reg <= 1'b0;
        end
    end

    // ****************************************
    // link shifter
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b0;
            bit_cnt_reg <= 5'h00;
            shift_reg <= 24'h000000;
            rd_byte_reg <= 8'h00;
            frame_mode_reg <= 2'h0;
            spi_miso <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            if (cs_n_s) begin
                bit_cnt_reg <= 5'h00;
                frame_mode_reg <= format_reg[`ACFG_FM_MODE_HI:`ACFG_FM_MODE_LO];
                spi_miso <= 1'b0;
            end else begin
                if (sample_edge) begin
                    shift_reg <= shift_next;
                    bit_cnt_reg <= frame_done ? 5'h00 : bit_cnt_reg + 5'h1;
                end
                if (addr_ready) begin
                    rd_byte_reg <= rd_op ? rd_value : 8'h00;
                end
                if (shift_edge && bit_cnt_reg >= `ACFG_DATA_START) begin
                    spi_miso <= rd_byte_reg[3'h7 - out_idx[2:0]];
                end
            end
        end
    end

    // ****************************************
    // control outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            crc_enable <= 1'b0;
            minmax_clear <= 1'b0;
            minmax_update <= 1'b0;
            window_compare_enable <= 1'b0;
            window_compare_reset <= 1'b1;
            force_analog_all <= 1'b0;
            trim_start <= 1'b0;
            spi_mode <= 2'h0;
            averaging_ratio <= 3'h0;
            average_samples <= 8'h01;
        end else begin
            crc_enable <= global_reg[`ACFG_GL_CRC];
            minmax_clear <= minmax_rise;
            minmax_update <= global_next[`ACFG_GL_MINMAX] & ~minmax_rise;
            window_compare_enable <= global_reg[`ACFG_GL_WINDOW];
            window_compare_reset <= ~global_reg[`ACFG_GL_WINDOW];
            force_analog_all <= global_reg[`ACFG_GL_FORCE];
            trim_start <= trim_set;
            spi_mode <= format_reg[`ACFG_FM_MODE_HI:`ACFG_FM_MODE_LO];
            averaging_ratio <= avg_reg[`ACFG_AV_RATIO_HI:0];
            average_samples <= 8'h01 << avg_reg[`ACFG_AV_RATIO_HI:0];
        end
    end

    // ****************************************
    // output data formatting
    // ****************************************
    wire [1:0] tag_sel = format_reg[`ACFG_FM_TAG_HI:`ACFG_FM_TAG_LO];
    wire [11:0] data_sel = format_reg[`ACFG_FM_PATTERN] ? `ACFG_TEST_CODE : conv_data;
    // no tag, reserved treated as none
    wire [3:0] tag_bits = (tag_sel == ACFG_TAG_CHANNEL) ? conv_channel :
        (tag_sel == ACFG_TAG_STATUS) ? conv_status : 4'h0;
    wire tag_on = (tag_sel == ACFG_TAG_CHANNEL) || (tag_sel == ACFG_TAG_STATUS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_word <= 16'h0000;
            out_tag_valid <= 1'b0;
        end else begin
            out_valid <= conv_valid;
            if (conv_valid) begin
                out_word <= {data_sel, tag_bits};
                out_tag_valid <= tag_on;
            end
        end
    end
endmodule // acfg_reg_bank

// *** sim/acfg_spi_host.sv ***
`timescale 1ns/100ps
// ****
// host side of the serial link
// ****
module acfg_spi_host (
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    // idle level set while deselected, the mode is taken then
    task automatic xfer(input logic [1:0] m, input logic [23:0] w, output logic [7:0] r);
        spi_sclk = m[1];
        #600 spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            if (!m[0]) spi_mosi = w[i];
            #200 spi_sclk = ~spi_sclk;
            if (m[0]) spi_mosi = w[i];
            else r = {r[6:0], spi_miso};
            #200 spi_sclk = ~spi_sclk;
            if (m[0]) r = {r[6:0], spi_miso};
        end
        #200 spi_cs_n = 1'b1;
        // flipped so stale data never looks valid
        spi_mosi = ~spi_mosi;
    endtask
endmodule // acfg_spi_host

// *** sim/acfg_reg_bank_props.sv ***
`timescale 1ns/100ps
// ****
// port checks
// ****
module acfg_chk
    import acfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic conv_valid,
    input wire logic [11:0] conv_data,
    input wire logic [3:0] conv_channel,
    input wire logic [3:0] conv_status,
    input wire logic minmax_clear,
    input wire logic minmax_update,
    input wire logic window_compare_enable,
    input wire logic window_compare_reset,
    input wire logic trim_start,
    input wire acfg_pkg::acfg_ratio_t averaging_ratio,
    input wire logic [7:0] average_samples,
    input wire logic out_valid,
    input wire logic [15:0] out_word,
    input wire logic out_tag_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_win; window_compare_reset != window_compare_enable; endproperty
    a_win: assert property (p_win) else $error("window reset");
    property p_clr;
        minmax_clear |-> !minmax_update ##1 (minmax_update && !minmax_clear);
    endproperty
    a_clr: assert property (p_clr) else $error("minmax clear");
    property p_upd; $rose(minmax_update) |-> $past(minmax_clear); endproperty
    a_upd: assert property (p_upd) else $error("minmax update");
    property p_trim; trim_start |=> !trim_start; endproperty
    a_trim: assert property (p_trim) else $error("trim pulse");
    property p_avg; average_samples == (8'h01 << averaging_ratio); endproperty
    a_avg: assert property (p_avg) else $error("samples");
    property p_out;
        conv_valid |=> out_valid
            && (out_word[15:4] == $past(conv_data) || out_word[15:4] == 12'ha5a);
    endproperty
    a_out: assert property (p_out) else $error("out data");
    property p_tag;
        out_valid && out_tag_valid
            |-> out_word[3:0] == $past(conv_channel) || out_word[3:0] == $past(conv_status);
    endproperty
    a_tag: assert property (p_tag) else $error("out tag");
    property p_notag; out_valid && !out_tag_valid |-> out_word[3:0] == 4'h0; endproperty
    a_notag: assert property (p_notag) else $error("no tag");
    c_clr: cover property (minmax_clear);
    c_trim: cover property (trim_start);
    c_tag: cover property (out_valid && out_tag_valid);
endmodule // acfg_chk

bind acfg_reg_bank acfg_chk u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .conv_channel(conv_channel),
    .conv_status(conv_status),
    .minmax_clear(minmax_clear),
    .minmax_update(minmax_update),
    .window_compare_enable(window_compare_enable),
    .window_compare_reset(window_compare_reset),
    .trim_start(trim_start),
    .averaging_ratio(averaging_ratio),
    .average_samples(average_samples),
    .out_valid(out_valid),
    .out_word(out_word),
    .out_tag_valid(out_tag_valid)
);

// *** sim/tb_acfg_reg_bank.sv ***
`timescale 1ns/100ps
`include "acfg_defs.svh"
// ****
// register bank bench
// ****
module tb_acfg_reg_bank;
    import acfg_pkg::*;
    logic clk, rst_n, spi_cs_n, spi_sclk, spi_mosi, spi_miso, trim_done, conv_valid;
    logic crc_enable, minmax_clear, minmax_update, force_analog_all, trim_start;
    logic window_compare_enable, window_compare_reset, out_valid, out_tag_valid;
    logic [11:0] conv_data;
    logic [3:0] conv_channel, conv_status;
    acfg_spi_mode_t spi_mode;
    acfg_ratio_t averaging_ratio;
    logic [7:0] average_samples;
    logic [15:0] out_word;
    logic [1:0] mode = 2'h0;
    int err_count = 0;
    int checks_done = 0;
    int n_trim = 0;
    int n_clr = 0;
    acfg_reg_bank dut (
        .clk(clk),
        .rst_n(rst_n),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .trim_done(trim_done),
        .conv_valid(conv_valid),
        .conv_data(conv_data),
        .conv_channel(conv_channel),
        .conv_status(conv_status),
        .crc_enable(crc_enable),
        .minmax_clear(minmax_clear),
        .minmax_update(minmax_update),
        .window_compare_enable(window_compare_enable),
        .window_compare_reset(window_compare_reset),
        .force_analog_all(force_analog_all),
        .trim_start(trim_start),
        .spi_mode(spi_mode),
        .averaging_ratio(averaging_ratio),
        .average_samples(average_samples),
        .out_valid(out_valid),
        .out_word(out_word),
        .out_tag_valid(out_tag_valid)
    );
    acfg_spi_host host (
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // pulses counted mid-cycle, where they are settled
    always @(negedge clk) begin
        if (trim_start === 1'b1) n_trim++;
        if (minmax_clear === 1'b1) n_clr++;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer(mode, {`ACFG_OP_WRITE, a, d}, r);
        repeat (4) @(negedge clk);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        host.xfer(mode, {`ACFG_OP_READ, a, 8'h00}, r);
        chk(nm, {8'h00, e}, {8'h00, r});
    endtask
    task automatic conv(input logic [11:0] d, input logic [3:0] ch, input logic [3:0] st);
        int i;
        @(negedge clk);
        {conv_data, conv_channel, conv_status, conv_valid} = {d, ch, st, 1'b1};
        @(negedge clk) conv_valid = 1'b0;
        for (i = 0; i < 4 && out_valid !== 1'b1; i++) @(negedge clk);
        if (i == 4) begin
            err_count++;
            summarize();
        end
    endtask
    function automatic logic [15:0] flags();
        return {11'h0, crc_enable, minmax_update, window_compare_enable,
            force_analog_all, window_compare_reset};
    endfunction
    task automatic t_global();
        chk("flags", 16'h01, flags());
        rd("status", `ACFG_OFF_STATUS, 8'h81);
        wr(`ACFG_OFF_GLOBAL, 8'hfe);
        chk("flags", 16'h1e, flags());
        chk("force", 16'h1, {15'h0, force_analog_all});
        chk("clears", 16'h1, 16'(n_clr));
        chk("trims", 16'h1, 16'(n_trim));
        rd("global", `ACFG_OFF_GLOBAL, 8'h76);
        @(negedge clk) trim_done = 1'b1;
        @(negedge clk) trim_done = 1'b0;
        rd("global", `ACFG_OFF_GLOBAL, 8'h74);
        wr(`ACFG_OFF_GLOBAL, 8'h00);
        chk("flags", 16'h01, flags());
        $display("test global done");
    endtask
    task automatic t_format();
        for (int m = 3; m >= 0; m--) begin
            wr(`ACFG_OFF_FORMAT, 8'hdc | 8'(m));
            mode = 2'(m);
            chk("mode", 16'(m), {14'h0, spi_mode});
            rd("format", `ACFG_OFF_FORMAT, 8'h90 | 8'(m));
        end
        for (int t = 0; t < 4; t++) begin
            wr(`ACFG_OFF_FORMAT, {t[0], 1'b0, t[1:0], 4'h0});
            conv(12'h3c6, 4'h5, 4'h9);
            chk("data", t[0] ? 16'ha5a : 16'h3c6, {4'h0, out_word[15:4]});
            chk("tag", t == 1 ? 16'h5 : t == 2 ? 16'h9 : 16'h0, {12'h0, out_word[3:0]});
            chk("tagv", 16'(t == 1 || t == 2), {15'h0, out_tag_valid});
        end
        $display("test format done");
    endtask
    task automatic t_avg();
        for (int r = 0; r < 8; r++) begin
            wr(`ACFG_OFF_AVG, 8'hf8 | 8'(r));
            chk("samples", 16'h1 << r, {8'h0, average_samples});
            chk("ratio", 16'(r), {13'h0, averaging_ratio});
            rd("avg", `ACFG_OFF_AVG, 8'(r));
        end
        $display("test avg done");
    endtask
    task automatic t_soft();
        wr(`ACFG_OFF_STATUS, 8'h01);
        rd("status", `ACFG_OFF_STATUS, 8'h80);
        rd("unmapped", 8'h7f, 8'h00);
        wr(`ACFG_OFF_FORMAT, 8'h30);
        wr(`ACFG_OFF_GLOBAL, 8'h35);
        rd("global", `ACFG_OFF_GLOBAL, 8'h00);
        rd("format", `ACFG_OFF_FORMAT, 8'h00);
        rd("avg", `ACFG_OFF_AVG, 8'h00);
        rd("status", `ACFG_OFF_STATUS, 8'h81);
        chk("flags", 16'h01, flags());
        $display("test soft reset done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {rst_n, trim_done, conv_valid, conv_data, conv_channel, conv_status} = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_global();
        t_format();
        t_avg();
        t_soft();
        summarize();
    end
endmodule // tb_acfg_reg_bank
